/* File: design/cosd_top.sv */
// Output alignment block with an AHB-Lite register slave.
// Assumes a single master, whole-word single transfers, and an
// asynchronous alignment request pin.
//
// Design decisions made here: register access over AHB-Lite and the placing of the registers.
`timescale 1ns/10ps
`include "cosd_map.svh"

// Behaviour
// RQ1: Request held high at least 1 ms
// RQ2: Gate-enabled outputs gated; others run freely
// RQ3: Request retimed to clk drives all gating
// RQ4: Gated output stays low while aligning
// RQ5: Outputs fall only at normal fall edge (code: with modulus 0 or 1 the gated output drops at once)
// RQ6: Zero-delay outputs rise together on release
// RQ7: Each output delays rise 0 to 63 cycles
// RQ8: Delay counting stops once alignment completes
// RQ9: Shared request, skew under 10 us
// RQ10: Shared request line, no precise timing
// RQ11: Follower only, relies on gated input clock
// RQ12: Whole input cycles only, no time compensation
// RQ13: Count cycles after release, start at delay
// RQ14: Gate disabled bypasses delay logic entirely
// RQ15: Divide by 1 to 63, 50 percent duty; odd moduli stay high one cycle longer than low (code: moduli 0 and 1 hold the output constantly high)
// RQ16: Two-flop synchroniser for the request
module cosd_top #(
  parameter int ADDR_W = 12
) (
  input  wire logic              clk,
  input  wire logic              rst,
  input  wire logic              align_request,
  input  wire logic              hsel,
  input  wire logic [ADDR_W-1:0] haddr,
  input  wire logic [1:0]        htrans,
  input  wire logic              hwrite,
  input  wire logic [2:0]        hsize,
  input  wire logic [31:0]       hwdata,
  input  wire logic              hready,
  output logic                   hreadyout,
  output logic                   hresp,
  output logic [31:0]            hrdata,
  output logic [2:0]             divided_clock_output
);

  localparam int N = `COSD_NUM_OUT;

  logic [7:0]        del_reg [N];
  logic [7:0]        next_del_reg [N];
  logic [7:0]        mod_reg [N];
  logic [7:0]        next_mod_reg [N];
  logic              a_valid;
  logic              next_a_valid;
  logic              a_write;
  logic              next_a_write;
  logic [7:0]        a_idx;
  logic [7:0]        next_a_idx;
  logic [31:0]       next_hrdata;
  logic              retimed_align_signal;
  logic [N-1:0]      busy;
  logic [N-1:0]      outs;
  logic              addr_ok;
  logic [7:0]        req_idx;

  cosd_chan_if chif[N] ();

  ////////////////////////////////////////////////////////////////////////////
  // Request retiming; its output alone steers every channel
  cosd_sync2 u_sync (
    .clk      (clk),
    .rst      (rst),
    .async_in (align_request),
    .sync_out (retimed_align_signal) // [RQ3] [RQ16]
  );

  // Follower only: the input clock is clk, no controller outputs [RQ11]
  for (genvar i = 0; i < N; i++) begin : g_ch
    assign chif[i].output_divide_modulus = mod_reg[i][`COSD_FIELD_MSB:0];
    assign chif[i].start_delay_cycles    = del_reg[i][`COSD_FIELD_MSB:0];
    assign chif[i].align_gate_enable     = del_reg[i][`COSD_EN_BIT];
    assign chif[i].retimed_align_signal  = retimed_align_signal; // [RQ3]
    assign outs[i] = chif[i].divided_clock_output;
    assign busy[i] = chif[i].busy;
    cosd_chan u_ch (
      .clk (clk),
      .rst (rst),
      .ch  (chif[i])
    );
  end

  // Channel output flops drive the pins directly
  assign divided_clock_output = outs;

  ////////////////////////////////////////////////////////////////////////////
  // Bus address phase
  always_comb begin
    addr_ok = haddr[1:0] == 2'b00 && hsize == 3'b010;
    req_idx = 8'(haddr >> 2);
    if (ADDR_W > 10) begin
      addr_ok = addr_ok && (haddr >> 10) == '0;
    end
    next_a_valid = hsel && htrans[1] && hready;
    next_a_write = hwrite;
    next_a_idx   = addr_ok ? req_idx : 8'hFF;
    if (!next_a_valid) begin
      next_a_write = 1'b0;
      next_a_idx   = 8'hFF;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      a_valid <= 1'b0;
      a_write <= 1'b0;
      a_idx   <= 8'hFF;
    end else begin
      a_valid <= next_a_valid;
      a_write <= next_a_write;
      a_idx   <= next_a_idx;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Register writes in the data phase; bit 6 and unused bits read zero
  always_comb begin
    for (int i = 0; i < N; i++) begin
      next_del_reg[i] = del_reg[i];
      next_mod_reg[i] = mod_reg[i];
      if (a_valid && a_write) begin
        if (a_idx == `COSD_IDX_DEL0 + 8'(2 * i)) begin
          next_del_reg[i] = hwdata[7:0] & 8'hBF;
        end
        if (a_idx == `COSD_IDX_MOD0 + 8'(2 * i)) begin
          next_mod_reg[i] = hwdata[7:0] & 8'h3F;
        end
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      del_reg[0] <= `COSD_RST_DEL & 8'hBF;
      del_reg[1] <= `COSD_RST_DEL & 8'hBF;
      del_reg[2] <= `COSD_RST_DEL & 8'hBF;
      mod_reg[0] <= `COSD_RST_MOD0;
      mod_reg[1] <= `COSD_RST_MOD1;
      mod_reg[2] <= `COSD_RST_MOD2;
    end else begin
      del_reg <= next_del_reg;
      mod_reg <= next_mod_reg;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read data chosen in the address phase from the next values, so a read
  // right after a write sees the new contents with zero wait states
  always_comb begin
    next_hrdata = 32'h0000_0000;
    if (next_a_valid && !hwrite) begin
      for (int i = 0; i < N; i++) begin
        if (next_a_idx == `COSD_IDX_DEL0 + 8'(2 * i)) begin
          next_hrdata = {24'h00_0000, next_del_reg[i]};
        end
        if (next_a_idx == `COSD_IDX_MOD0 + 8'(2 * i)) begin
          next_hrdata = {24'h00_0000, next_mod_reg[i]};
        end
      end
      if (next_a_idx == `COSD_IDX_STATUS) begin
        next_hrdata[0] = retimed_align_signal;
        next_hrdata[`COSD_ST_BUSY_LSB +: N] = busy;
        next_hrdata[`COSD_ST_OUT_LSB +: N]  = outs;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      hrdata    <= 32'h0000_0000;
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end else begin
      hrdata    <= next_hrdata;
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  a_sync_two_stage: assert property (@(posedge clk) disable iff (rst) // [RQ16]
    $rose(retimed_align_signal) |-> $past(align_request, 2))
    else $error("Retimed align did not follow request by two flops");

endmodule // cosd_top

/* File: inc/cosd_map.svh */
// Register map, field positions and reset values of the output aligner.
// Assumes a word-wide bus slave: byte address is four times the index.
`ifndef COSD_MAP_SVH
`define COSD_MAP_SVH

`define COSD_NUM_OUT     3
`define COSD_IDX_DEL0    8'h01
`define COSD_IDX_MOD0    8'h02
`define COSD_IDX_DEL1    8'h03
`define COSD_IDX_MOD1    8'h04
`define COSD_IDX_DEL2    8'h05
`define COSD_IDX_MOD2    8'h06
`define COSD_IDX_STATUS  8'h08
`define COSD_EN_BIT      7
`define COSD_FIELD_MSB   5
`define COSD_RST_DEL     8'hC0
`define COSD_RST_MOD0    8'h02
`define COSD_RST_MOD1    8'h04
`define COSD_RST_MOD2    8'h08
`define COSD_ST_BUSY_LSB 1
`define COSD_ST_OUT_LSB  4

`endif

/* File: inc/cosd_pkg.sv */
// Types shared by the output aligner modules.
// Assumes nothing beyond a SystemVerilog compiler.
package cosd_pkg;

  typedef enum logic [1:0] {
    CH_RUN,
    CH_HOLD,
    CH_WAIT
  } cosd_ch_state_t;

endpackage

/* File: inc/cosd_chan_if.sv */
// Settings and status carried between the top and one output channel.
// Assumes both ends run on the same clock.
`timescale 1ns/10ps

interface cosd_chan_if;
  logic [5:0] output_divide_modulus;
  logic [5:0] start_delay_cycles;
  logic       align_gate_enable;
  logic       retimed_align_signal;
  logic       divided_clock_output;
  logic       busy;

  modport top  (output output_divide_modulus,
                output start_delay_cycles,
                output align_gate_enable,
                output retimed_align_signal,
                input  divided_clock_output,
                input  busy);
  modport chan (input  output_divide_modulus,
                input  start_delay_cycles,
                input  align_gate_enable,
                input  retimed_align_signal,
                output divided_clock_output,
                output busy);
endinterface // cosd_chan_if

/* File: design/cosd_sync2.sv */
// Two-stage synchroniser for a level from outside the clock domain.
// Assumes the input may change at any time relative to clk.
`timescale 1ns/10ps

module cosd_sync2 (
  input  wire logic clk,
  input  wire logic rst,
  input  wire logic async_in,
  output logic      sync_out
);

  logic meta;
  logic next_meta;
  logic next_sync_out;

  always_comb begin
    next_meta     = async_in;
    next_sync_out = meta;
  end

  // First stage feeds only the second stage
  always_ff @(posedge clk) begin
    if (rst) begin
      meta     <= 1'b0;
      sync_out <= 1'b0;
    end else begin
      meta     <= next_meta;
      sync_out <= next_sync_out;
    end
  end

endmodule // cosd_sync2

/* File: design/cosd_chan.sv */
// One output channel: divider, alignment gate and start delay counter.
// Assumes the align level is already retimed to clk.
`timescale 1ns/10ps

module cosd_chan (
  input  wire logic    clk,
  input  wire logic    rst,
  cosd_chan_if.chan    ch
);

  cosd_pkg::cosd_ch_state_t st;
  cosd_pkg::cosd_ch_state_t next_st;
  logic [5:0] cnt;
  logic [5:0] next_cnt;
  logic [5:0] dcnt;
  logic [5:0] next_dcnt;
  logic       out;
  logic       next_out;
  logic [5:0] hi;
  logic       bypass;
  logic [5:0] div_cnt;
  logic       div_out;

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    next_st   = st;
    next_cnt  = cnt;
    next_dcnt = 6'h00;
    next_out  = out;
    hi        = 6'((7'(ch.output_divide_modulus) + 7'h01) >> 1); // [RQ15]
    bypass    = ch.output_divide_modulus <= 6'h01;               // [RQ15]
    if (bypass || cnt >= ch.output_divide_modulus - 6'h01) begin
      div_cnt = 6'h00;
    end else begin
      div_cnt = cnt + 6'h01;
    end
    div_out = bypass | (div_cnt < hi);
    unique case (st)
      cosd_pkg::CH_RUN: begin
        next_cnt = div_cnt;
        next_out = div_out;
        // Fall only where the plain waveform falls, or at once in bypass: no runt pulse
        if (ch.align_gate_enable && ch.retimed_align_signal &&
            (!div_out || bypass)) begin // [RQ2] [RQ4] [RQ5]
          next_st  = cosd_pkg::CH_HOLD;
          next_out = 1'b0;
        end
      end
      cosd_pkg::CH_HOLD: begin
        next_out = 1'b0; // [RQ4]
        next_cnt = 6'h00;
        if (!ch.align_gate_enable) begin
          next_st = cosd_pkg::CH_RUN; // [RQ14]
        end else if (!ch.retimed_align_signal) begin
          if (ch.start_delay_cycles == 6'h00) begin
            next_st  = cosd_pkg::CH_RUN; // [RQ6]
            next_out = 1'b1;
          end else begin
            next_st = cosd_pkg::CH_WAIT; // [RQ13]
          end
        end
      end
      cosd_pkg::CH_WAIT: begin
        next_out  = 1'b0;
        next_cnt  = 6'h00;
        next_dcnt = dcnt + 6'h01; // [RQ13] [RQ12]
        if (!ch.align_gate_enable) begin
          next_st   = cosd_pkg::CH_RUN; // [RQ14]
          next_dcnt = 6'h00;
        end else if (ch.retimed_align_signal) begin
          next_st   = cosd_pkg::CH_HOLD; // [RQ4]
          next_dcnt = 6'h00;
        end else if (dcnt + 6'h01 == ch.start_delay_cycles) begin
          next_st   = cosd_pkg::CH_RUN; // [RQ7]
          next_out  = 1'b1;
          next_dcnt = 6'h00; // Counter idles once aligned [RQ8]
        end
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      st   <= cosd_pkg::CH_RUN;
      cnt  <= 6'h00;
      dcnt <= 6'h00;
      out  <= 1'b1;
    end else begin
      st   <= next_st;
      cnt  <= next_cnt;
      dcnt <= next_dcnt;
      out  <= next_out;
    end
  end

  assign ch.divided_clock_output = out;
  assign ch.busy                 = st != cosd_pkg::CH_RUN;

  ////////////////////////////////////////////////////////////////////////////
  a_hold_output_low: assert property (@(posedge clk) disable iff (rst) // [RQ4]
    st == cosd_pkg::CH_HOLD |-> !out)
    else $error("Output high while held for alignment");

  a_gate_off_runs: assert property (@(posedge clk) disable iff (rst) // [RQ2]
    !ch.align_gate_enable |=> st == cosd_pkg::CH_RUN)
    else $error("Ungated output left its free-running state");

  a_zero_delay_rise: assert property (@(posedge clk) disable iff (rst) // [RQ6]
    st == cosd_pkg::CH_HOLD && ch.align_gate_enable &&
    !ch.retimed_align_signal && ch.start_delay_cycles == 6'h00
    |=> out && st == cosd_pkg::CH_RUN)
    else $error("Zero-delay output did not rise on align release");

  a_delay_end_rise: assert property (@(posedge clk) disable iff (rst) // [RQ7]
    st == cosd_pkg::CH_WAIT && ch.align_gate_enable &&
    !ch.retimed_align_signal &&
    dcnt == ch.start_delay_cycles - 6'h01 |=> out)
    else $error("Delayed output did not rise at its count");

  a_counter_idle: assert property (@(posedge clk) disable iff (rst) // [RQ8]
    st != cosd_pkg::CH_WAIT |-> dcnt == 6'h00)
    else $error("Delay counter running outside an alignment");

  a_fall_from_run: assert property (@(posedge clk) disable iff (rst) // [RQ5]
    $fell(out) |-> $past(st) == cosd_pkg::CH_RUN &&
                   (!$past(div_out) || $past(bypass)))
    else $error("Output fell away from its divided waveform edge");

  a_divider_duty: assert property (@(posedge clk) disable iff (rst) // [RQ15]
    st == cosd_pkg::CH_RUN && $past(st) == cosd_pkg::CH_RUN &&
    ch.output_divide_modulus > 6'h01 && $stable(ch.output_divide_modulus)
    |-> out == (cnt < hi))
    else $error("Divided output does not match its phase count");

endmodule // cosd_chan

/* File: verif/cosd_align_src.sv */
// Model of the alignment pulse source that drives the request pin.
// Assumes one clock; MIN_HOLD stands in for the long minimum pulse.
`timescale 1ns/10ps

module cosd_align_src #(
  parameter int MIN_HOLD = 120
) (
  input  wire logic       clk,
  input  wire logic       go,
  input  wire logic [4:0] extra,
  output logic            align_request
);
  int unsigned cnt;

  initial begin
    align_request = 1'b0;
    cnt           = 0;
  end

  // Scaled minimum hold; extra makes the source slow at will
  // One shared line, no precise timing needed
  always @(posedge clk) begin
    if (go && cnt == 0) begin
      align_request <= 1'b1;
      cnt           <= MIN_HOLD + extra;
    end else if (cnt > 1) begin
      cnt <= cnt - 1;
    end else if (cnt == 1) begin
      cnt           <= 0;
      align_request <= 1'b0;
    end
  end
endmodule // cosd_align_src

/* File: verif/testbench.sv */
// Self-checking bench for the output aligner.
// Assumes the top with zero-wait AHB-Lite slave and the source model.
`timescale 1ns/10ps

module testbench;
  logic        clk    = 1'b0;
  logic        rst    = 1'b1;
  logic        go     = 1'b0;
  logic        hsel   = 1'b0;
  logic        hwrite = 1'b0;
  logic [11:0] haddr  = 12'h000;
  logic [1:0]  htrans = 2'b00;
  logic [2:0]  hsize  = 3'b010;
  logic [31:0] hwdata = 32'h0000_0000;
  logic [4:0]  extra  = 5'h00;
  logic        hreadyout;
  logic        hresp;
  logic [31:0] hrdata;
  logic [2:0]  dco;
  logic        areq;
  int          fails    = 0;
  int          n_checks = 0;
  int          seed;
  int          m [3];
  int          d [3];
  logic        en [3];

  always #2 clk = ~clk;

  cosd_top u_dut (
    .clk                  (clk),
    .rst                  (rst),
    .align_request        (areq),
    .hsel                 (hsel),
    .haddr                (haddr),
    .htrans               (htrans),
    .hwrite               (hwrite),
    .hsize                (hsize),
    .hwdata               (hwdata),
    .hready               (hreadyout),
    .hreadyout            (hreadyout),
    .hresp                (hresp),
    .hrdata               (hrdata),
    .divided_clock_output (dco)
  );

  cosd_align_src #(.MIN_HOLD(120)) u_src (
    .clk           (clk),
    .go            (go),
    .extra         (extra),
    .align_request (areq)
  );

  ////////////////////////////////////////////////////////////////////////
  task automatic chk_reg(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      fails++;
      $display("CHECK FAILED t=%0t value %h expected %h", $time, got, exp);
    end
  endtask

  task automatic chk_num(input int got, input int exp);
    n_checks++;
    if (got != exp) begin
      fails++;
      $display("CHECK FAILED t=%0t count %0d expected %0d", $time, got, exp);
    end
  endtask

  // Address phase held until hready, then data phase until hready
  task automatic bus(input logic w, input logic [7:0] idx,
                     input logic [31:0] wd, output logic [31:0] rd);
    @(posedge clk);
    hsel   <= 1'b1;
    haddr  <= {2'b00, idx, 2'b00};
    htrans <= 2'b10;
    hwrite <= w;
    do @(posedge clk); while (hreadyout !== 1'b1);
    hsel   <= 1'b0;
    htrans <= 2'b00;
    hwdata <= wd;
    do @(posedge clk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask

  task automatic wr(input logic [7:0] idx, input logic [31:0] v);
    logic [31:0] r;
    bus(1'b1, idx, v, r);
  endtask

  task automatic rd_chk(input logic [7:0] idx, input logic [31:0] exp);
    logic [31:0] r;
    bus(1'b0, idx, 32'h0000_0000, r);
    chk_reg(r, exp);
    chk_reg({31'h0, hresp}, 32'h0000_0000);
  endtask

  function automatic int exp_hi(input int mm);
    return (mm < 2) ? 2 : mm + (mm % 2);
  endfunction

  function automatic int win(input int mm);
    return (mm < 2) ? 2 : 2 * mm;
  endfunction

  // Rise lands three edges after the pin falls, plus the delay
  function automatic int exp_rise(input int dd);
    return 3 + dd;
  endfunction

  ////////////////////////////////////////////////////////////////////////
  task automatic run_round(input int r);
    int          hi [3];
    int          first [3];
    int          seen [3];
    logic [2:0]  prev;
    logic [31:0] st;
    for (int i = 0; i < 3; i++) begin
      wr(8'(2 * i + 1), {24'h0, en[i], 1'b0, 6'(d[i])});
      wr(8'(2 * i + 2), 32'(m[i]));
      rd_chk(8'(2 * i + 1), {24'h0, en[i], 1'b0, 6'(d[i])});
    end
    // Let dividers settle after a modulus change
    repeat (130) @(posedge clk);
    hi = '{0, 0, 0};
    for (int k = 0; k < 126; k++) begin
      @(posedge clk);
      #1;
      for (int i = 0; i < 3; i++)
        if (k < win(m[i])) hi[i] += int'(dco[i]);
    end
    for (int i = 0; i < 3; i++)
      chk_num(hi[i], exp_hi(m[i]));
    @(posedge clk);
    go    <= 1'b1;
    extra <= 5'($urandom_range(30));
    @(posedge clk);
    go   <= 1'b0;
    prev = dco;
    seen = '{0, 0, 0};
    for (int k = 0; k < 90; k++) begin
      @(posedge clk);
      #1;
      for (int i = 0; i < 3; i++) begin
        if (dco[i] !== prev[i] && !$isunknown(dco[i])) seen[i] = 1;
        if (k >= 70 && en[i]) chk_reg({31'h0, dco[i]}, 32'h0);
      end
      prev = dco;
    end
    for (int i = 0; i < 3; i++)
      if (!en[i] && m[i] > 1) chk_num(seen[i], 1);
    bus(1'b0, 8'h08, 32'h0000_0000, st);
    chk_reg({28'h0, st[3:0]}, {28'h0, en[2], en[1], en[0], 1'b1});
    @(negedge areq);
    first = '{-1, -1, -1};
    for (int k = 1; k <= 70; k++) begin
      @(posedge clk);
      #1;
      for (int i = 0; i < 3; i++)
        if (first[i] < 0 && dco[i] === 1'b1) first[i] = k;
    end
    for (int i = 0; i < 3; i++)
      if (en[i]) chk_num(first[i], exp_rise(d[i]));
    bus(1'b0, 8'h08, 32'h0000_0000, st);
    chk_reg({28'h0, st[3:0]}, 32'h0);
    $display("round %0d done", r);
  endtask

  task automatic print_verdict;
    $display("checks %0d mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////
  initial begin
    #80000;
    fails++;
    print_verdict();
  end

  initial begin
    seed = $urandom(19);
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    // Stray write to an unmapped word must not disturb anything
    wr(8'h07, 32'h0000_00FF);
    rd_chk(8'h07, 32'h0000_0000);
    rd_chk(8'h01, 32'h0000_0080);
    rd_chk(8'h06, 32'h0000_0008);
    $display("reset test done");
    for (int r = 0; r < 8; r++) begin
      for (int i = 0; i < 3; i++) begin
        m[i]  = $urandom_range(63);
        d[i]  = $urandom_range(63);
        en[i] = 1'($urandom_range(1));
      end
      // Corners: all zero delay together, then extreme delays
      if (r == 0) begin
        m  = '{4, 4, 4};
        d  = '{0, 0, 0};
        en = '{1'b1, 1'b1, 1'b1};
      end else if (r == 1) begin
        m  = '{1, 63, 0};
        d  = '{63, 0, 5};
        en = '{1'b1, 1'b1, 1'b0};
      end
      run_round(r);
    end
    print_verdict();
  end
endmodule // testbench
